// File: rtl/bcnt_top.v
`timescale 1ns/1ns
`include "bcnt_defs.vh"

module bcnt_top #(
  parameter [31:0] AU_ERASE_CYCLES = `BCNT_AU_ERASE_CYCLES  // single unit erase limit
) (
  input  wire        ref_clk,             // core clock, 100 MHz
  input  wire        reset,               // async, active high
  input  wire        link_clk,            // card bus clock pin
  input  wire        cmd_valid,           // decoded command strobe
  input  wire [5:0]  cmd_index,           // command index
  input  wire        cmd_is_app,          // application command
  input  wire [31:0] cmd_arg,             // command argument
  input  wire        cmd_crc_ok,          // command crc good
  input  wire        in_transfer_state,   // card in transfer state
  input  wire        high_capacity,       // fixed 512-byte blocks
  input  wire        ultra_capacity,      // keeps count across status
  input  wire        protected_supported, // protected commands present
  input  wire        fast_bus_mode,       // fastest single-ended mode
  input  wire        prev_error,          // error left by earlier command
  input  wire        block_done,          // one data block moved
  input  wire        user_area_end,       // address hit user area end
  input  wire        erase_busy,          // erasing one unit
  output reg         resp_valid,          // response ready pulse
  output reg  [5:0]  resp_index,          // index being answered
  output reg         resp_illegal,        // illegal command flag
  output reg         resp_error,          // carried-over error flag
  output reg         resp_busy,           // busy after response
  output reg         xfer_active,         // multi-block transfer running
  output reg         xfer_counted,        // transfer bounded by count
  output reg         xfer_write,          // transfer direction write
  output reg         xfer_end,            // automatic end pulse
  output reg         xfer_discard,        // excess block dropped pulse
  output reg  [15:0] xfer_block_bytes,    // block size in use
  output reg         out_of_range,        // range error, sticky
  output reg         card_config_register_cnt_support, // count support bit
  output reg  [15:0] erase_time_param,    // erase time, seconds
  output reg  [15:0] erase_unit_count_param, // units for erase time
  output reg  [7:0]  erase_offset_param,  // erase offset, seconds
  output reg         erase_params_ok,     // slope below limit
  output reg         erase_overrun        // unit erase too long, sticky
);

  // ****************************************
  // states
  // ****************************************
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_XFER  = 3'h2;
  localparam [2:0] ST_SPILL = 3'h4;

  function is_cmd;
    input [5:0] idx;
    input       app;
    input [5:0] want;
    input       want_app;
    begin
      is_cmd = (idx == want) && (app == want_app);
    end
  endfunction

  // ****************************************
  // link clock sampling
  // ****************************************
  reg link_meta;
  reg link_sync;
  reg link_prev;
  wire link_rise = link_sync & ~link_prev;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      link_meta <= 1'b0;
      link_sync <= 1'b0;
      link_prev <= 1'b0;
    end else begin
      link_meta <= link_clk;
      link_sync <= link_meta;
      link_prev <= link_sync;
    end
  end

  // ****************************************
  // command decode
  // ****************************************
  wire good     = cmd_valid & cmd_crc_ok;
  wire c_count  = is_cmd(cmd_index, cmd_is_app, `BCNT_CMD_SET_COUNT, 1'b0);
  wire c_mread  = is_cmd(cmd_index, cmd_is_app, `BCNT_CMD_MULTI_READ, 1'b0);
  wire c_mwrite = is_cmd(cmd_index, cmd_is_app, `BCNT_CMD_MULTI_WRITE, 1'b0);
  wire c_pread  = is_cmd(cmd_index, cmd_is_app, `BCNT_ACMD_PROT_READ, 1'b1);
  wire c_pwrite = is_cmd(cmd_index, cmd_is_app, `BCNT_ACMD_PROT_WRITE, 1'b1);
  wire c_status = is_cmd(cmd_index, cmd_is_app, `BCNT_CMD_STATUS, 1'b0);
  wire c_stop   = is_cmd(cmd_index, cmd_is_app, `BCNT_CMD_STOP, 1'b0);
  wire c_multi  = c_mread | c_mwrite;
  wire c_prot   = c_pread | c_pwrite;
  wire supported = card_config_register_cnt_support;

  reg                      pending;      // a count is armed
  reg [`BCNT_COUNT_W-1:0]  pending_count;
  reg [2:0]                state;
  reg [2:0]                next_state;
  wire                     last_block;

  // which commands consume an armed count
  wire use_multi = good & c_multi & pending & high_capacity;
  wire use_prot  = good & c_prot & pending & protected_supported;
  wire start_cnt = use_multi | use_prot;
  wire start_any = good & (c_multi | (c_prot & protected_supported & pending));
  wire illegal_now = good & ((c_count & (~in_transfer_state | ~supported))
                   | (c_prot & (~pending | ~protected_supported)));
  wire stop_now  = good & c_stop;
  wire blk_in    = block_done & (state == ST_XFER);
  wire auto_end  = blk_in & xfer_counted & last_block;

  // ****************************************
  // armed count
  // ****************************************
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pending       <= 1'b0;
      pending_count <= {`BCNT_COUNT_W{1'b0}};
    end else if (good) begin
      if (c_count && in_transfer_state && supported) begin
        // unchecked value, newest wins, zero disarms
        pending       <= (cmd_arg != 32'h0000_0000);
        pending_count <= cmd_arg;
      end else if (c_status && ultra_capacity) begin
        pending <= pending;
      end else begin
        pending <= 1'b0;
      end
    end
  end

  // ****************************************
  // transfer state machine
  // ****************************************
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_any && !illegal_now) begin
          next_state = ST_XFER;
        end
      end
      ST_XFER: begin
        if (stop_now || user_area_end) begin
          next_state = ST_IDLE;
        end else if (auto_end) begin
          next_state = ST_SPILL;
        end
      end
      ST_SPILL: begin
        if (good) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state            <= ST_IDLE;
      xfer_active      <= 1'b0;
      xfer_counted     <= 1'b0;
      xfer_write       <= 1'b0;
      xfer_end         <= 1'b0;
      xfer_discard     <= 1'b0;
      xfer_block_bytes <= `BCNT_FIXED_BLOCK;
      out_of_range     <= 1'b0;
    end else begin
      state        <= next_state;
      xfer_active  <= (next_state == ST_XFER);
      xfer_end     <= auto_end;
      // blocks past the count are dropped, never stored
      xfer_discard <= block_done & (state == ST_SPILL);
      if (state == ST_IDLE && next_state == ST_XFER) begin
        xfer_counted     <= start_cnt;
        xfer_write       <= c_mwrite | c_pwrite;
        // protected commands always move 512-byte blocks
        xfer_block_bytes <= `BCNT_FIXED_BLOCK;
      end else if (next_state == ST_IDLE) begin
        xfer_counted <= 1'b0;
      end
      // set wins over the clear on reporting
      if (state == ST_XFER && user_area_end) begin
        out_of_range <= 1'b1;
      end else if (resp_valid) begin
        out_of_range <= 1'b0;
      end
    end
  end

  bcnt_counter u_counter (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .load       (state == ST_IDLE && next_state == ST_XFER && start_cnt),
    .load_value (pending_count),
    .dec        (blk_in),
    .clear      (stop_now),
    .count      (),
    .last       (last_block)
  );

  // ****************************************
  // response, paced by link clock edges
  // ****************************************
  reg       resp_wait;
  reg [1:0] resp_edges;
  reg [5:0] hold_index;
  reg       hold_illegal;
  reg       hold_error;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      resp_wait    <= 1'b0;
      resp_edges   <= 2'h0;
      hold_index   <= 6'h00;
      hold_illegal <= 1'b0;
      hold_error   <= 1'b0;
      resp_valid   <= 1'b0;
      resp_index   <= 6'h00;
      resp_illegal <= 1'b0;
      resp_error   <= 1'b0;
      resp_busy    <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
      resp_busy  <= 1'b0;
      if (good) begin
        // crc failures never reach here, so no answer goes out
        resp_wait    <= 1'b1;
        resp_edges   <= 2'h0;
        hold_index   <= cmd_index;
        hold_illegal <= illegal_now;
        // count itself is never flagged, older errors still are
        hold_error   <= prev_error | out_of_range;
      end else if (resp_wait && link_rise) begin
        if (resp_edges == `BCNT_RESP_EDGES - 2'h1) begin
          resp_wait    <= 1'b0;
          resp_valid   <= 1'b1;
          resp_index   <= hold_index;
          resp_illegal <= hold_illegal;
          resp_error   <= hold_error;
        end else begin
          resp_edges <= resp_edges + 2'h1;
        end
      end
    end
  end

  // ****************************************
  // configuration and erase parameters
  // ****************************************
  reg [31:0] erase_cycles;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      card_config_register_cnt_support <= 1'b0;
      erase_time_param       <= `BCNT_ERASE_TIME_DEF;
      erase_unit_count_param <= `BCNT_ERASE_UNITS_DEF;
      erase_offset_param     <= `BCNT_ERASE_OFS_DEF;
      erase_params_ok        <= 1'b0;
      erase_cycles           <= 32'h0000_0000;
      erase_overrun          <= 1'b0;
    end else begin
      // mandatory for fast mode and protected commands
      card_config_register_cnt_support <= high_capacity | fast_bus_mode
                                        | protected_supported;
      // slope time/units must stay under three seconds per unit
      erase_params_ok <= (erase_unit_count_param != 16'h0000) &&
        ({16'h0000, erase_time_param} <
         {16'h0000, erase_unit_count_param} * {16'h0000, `BCNT_SLOPE_MAX_S});
      if (!erase_busy) begin
        erase_cycles <= 32'h0000_0000;
      end else if (erase_cycles != AU_ERASE_CYCLES) begin
        erase_cycles <= erase_cycles + 32'h0000_0001;
      end
      if (erase_busy && erase_cycles == AU_ERASE_CYCLES - 32'h0000_0001) begin
        erase_overrun <= 1'b1;
      end
    end
  end

endmodule // bcnt_top

// File: pkg/bcnt_defs.vh
`ifndef BCNT_DEFS_VH
`define BCNT_DEFS_VH

// ****************************************
// command indices
// ****************************************
`define BCNT_CMD_STOP        6'h0c
`define BCNT_CMD_STATUS      6'h0d
`define BCNT_CMD_MULTI_READ  6'h12
`define BCNT_CMD_SET_COUNT   6'h17
`define BCNT_CMD_MULTI_WRITE 6'h19
`define BCNT_ACMD_PROT_READ  6'h35
`define BCNT_ACMD_PROT_WRITE 6'h36

// ****************************************
// widths and fixed sizes
// ****************************************
`define BCNT_COUNT_W         32
`define BCNT_FIXED_BLOCK     16'h0200

// ****************************************
// response timing on the link clock
// ****************************************
`define BCNT_RESP_EDGES      2'h2

// ****************************************
// erase parameter defaults and limits
// ****************************************
`define BCNT_CLK_MHZ         100
`define BCNT_AU_ERASE_MAX_MS 3000
`define BCNT_AU_ERASE_CYCLES (`BCNT_AU_ERASE_MAX_MS * 1000 * `BCNT_CLK_MHZ)
`define BCNT_ERASE_TIME_DEF  16'h0006
`define BCNT_ERASE_UNITS_DEF 16'h0004
`define BCNT_ERASE_OFS_DEF   8'h01
`define BCNT_SLOPE_MAX_S     16'h0003

`endif

// File: rtl/bcnt_counter.v
`timescale 1ns/1ns
`include "bcnt_defs.vh"

module bcnt_counter (
  input  wire                      ref_clk,  // core clock
  input  wire                      reset,    // async, active high
  input  wire                      load,     // take load_value
  input  wire [`BCNT_COUNT_W-1:0]  load_value, // blocks to transfer
  input  wire                      dec,      // one block moved
  input  wire                      clear,    // abandon count
  output reg  [`BCNT_COUNT_W-1:0]  count,    // blocks still to go
  output reg                       last      // one block left
);

  // ****************************************
  // down counter
  // ****************************************
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      count <= {`BCNT_COUNT_W{1'b0}};
      last  <= 1'b0;
    end else if (clear) begin
      count <= {`BCNT_COUNT_W{1'b0}};
      last  <= 1'b0;
    end else if (load) begin
      count <= load_value;
      last  <= (load_value == {{(`BCNT_COUNT_W-1){1'b0}}, 1'b1});
    end else if (dec && count != {`BCNT_COUNT_W{1'b0}}) begin
      count <= count - {{(`BCNT_COUNT_W-1){1'b0}}, 1'b1};
      last  <= (count == {{(`BCNT_COUNT_W-2){1'b0}}, 2'h2});
    end
  end

endmodule // bcnt_counter

// File: bench/bcnt_properties.sv
`timescale 1ns/1ns

module bcnt_checker #(
  parameter [31:0] AU_ERASE_CYCLES = 32'h0000_0064
) (
  input wire        ref_clk,             // core clock
  input wire        reset,               // async, active high
  input wire        resp_busy,           // busy after response
  input wire        resp_valid,          // answer pulse
  input wire        xfer_end,            // auto end pulse
  input wire        xfer_active,         // transfer running
  input wire        user_area_end,       // boundary reached
  input wire        out_of_range,        // range error
  input wire [15:0] xfer_block_bytes,    // block size
  input wire        xfer_discard,        // excess dropped
  input wire        card_config_register_cnt_support, // support bit
  input wire        high_capacity,       // fixed blocks
  input wire        fast_bus_mode,       // fastest mode
  input wire        protected_supported, // protected commands
  input wire        erase_busy,          // unit erase running
  input wire        erase_overrun        // erase too long
);
  // ****************************************
  // helper: length of the current erase
  // ****************************************
  reg [31:0] busy_run;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) busy_run <= 32'h0;
    else if (erase_busy) busy_run <= busy_run + 32'h1;
    else busy_run <= 32'h0;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_never_busy: assert property (!resp_busy)
    else $error("busy shown after response");
  a_resp_pulse: assert property (resp_valid |=> !resp_valid)
    else $error("response strobe longer than one cycle");
  a_end_idle: assert property (xfer_end |-> !xfer_active)
    else $error("transfer still running at automatic end");
  a_range_stop: assert property (xfer_active && user_area_end |=> out_of_range && !xfer_active)
    else $error("boundary did not stop transfer with range error");
  a_fixed_block: assert property (xfer_block_bytes == 16'h0200)
    else $error("block size not fixed");
  a_support_bit: assert property (!$past(reset) |->
    card_config_register_cnt_support == $past(high_capacity | fast_bus_mode | protected_supported))
    else $error("support bit wrong");
  a_erase_limit: assert property (busy_run > AU_ERASE_CYCLES + 1 |-> erase_overrun)
    else $error("long erase not flagged");
  a_overrun_time: assert property ($rose(erase_overrun) |-> busy_run == AU_ERASE_CYCLES)
    else $error("erase overrun flagged at wrong time");
  a_drop_idle: assert property (xfer_discard |-> !xfer_active)
    else $error("block dropped while counted transfer runs");
endmodule // bcnt_checker

bind bcnt_top bcnt_checker #(.AU_ERASE_CYCLES(AU_ERASE_CYCLES)) u_chk (
  .ref_clk, .reset, .resp_busy, .resp_valid, .xfer_end, .xfer_active, .user_area_end,
  .out_of_range, .xfer_block_bytes, .xfer_discard, .card_config_register_cnt_support,
  .high_capacity, .fast_bus_mode, .protected_supported, .erase_busy, .erase_overrun
);

// File: bench/bcnt_host_model.sv
`timescale 1ns/1ns

module bcnt_host_model (
  input  wire go,       // frame open
  output reg  link_clk  // card bus clock
);
  // clock stands low between frames, but the period running when go falls still completes, so one edge can trail a frame
  initial begin
    link_clk = 1'b0;
    forever begin
      wait (go);
      #62 link_clk = 1'b1;
      #63 link_clk = 1'b0;
    end
  end
endmodule // bcnt_host_model

// File: bench/block_count_and_erase_timeout_test.sv
`timescale 1ns/1ns
`include "bcnt_defs.vh"

module block_count_and_erase_timeout_test;
  reg         ref_clk, reset, go, cmd_valid, cmd_is_app, cmd_crc_ok, got;
  reg         in_transfer_state, high_capacity, ultra_capacity, protected_supported;
  reg         fast_bus_mode, prev_error, block_done, user_area_end, erase_busy;
  reg  [5:0]  cmd_index;
  reg  [31:0] cmd_arg;
  wire        link_clk, resp_valid, resp_illegal, resp_error, resp_busy, xfer_active;
  wire        xfer_counted, xfer_write, xfer_end, xfer_discard, out_of_range;
  wire        card_config_register_cnt_support, erase_params_ok, erase_overrun;
  wire [5:0]  resp_index;
  wire [15:0] xfer_block_bytes, erase_time_param, erase_unit_count_param;
  wire [7:0]  erase_offset_param;
  integer     failures, cmp_count, n_end, n_drop;

  // short erase limit keeps the run brief
  bcnt_top #(.AU_ERASE_CYCLES(32'h0000_0064)) u_dut (
    .ref_clk, .reset, .link_clk, .cmd_valid, .cmd_index, .cmd_is_app, .cmd_arg,
    .cmd_crc_ok, .in_transfer_state, .high_capacity, .ultra_capacity,
    .protected_supported, .fast_bus_mode, .prev_error, .block_done, .user_area_end,
    .erase_busy, .resp_valid, .resp_index, .resp_illegal, .resp_error, .resp_busy,
    .xfer_active, .xfer_counted, .xfer_write, .xfer_end, .xfer_discard, .xfer_block_bytes,
    .out_of_range, .card_config_register_cnt_support, .erase_time_param,
    .erase_unit_count_param, .erase_offset_param, .erase_params_ok, .erase_overrun
  );
  bcnt_host_model u_host (.go(go), .link_clk(link_clk));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (xfer_end === 1'b1) n_end = n_end + 1;
    if (xfer_discard === 1'b1) n_drop = n_drop + 1;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input [95:0] nm, input [31:0] e, input [31:0] s);
    cmp_count = cmp_count + 1;
    if (s !== e) begin
      failures = failures + 1;
      $display("mismatch %0s expected %0h seen %0h", nm, e, s);
    end
  endtask

  // host erase timeout in ms; slope scaled before the divide to keep fractions
  function integer floor_ms(input integer ms);
    floor_ms = (ms < 1000) ? 1000 : ms;
  endfunction

  function integer tmo_ms(input integer x, input integer part, input integer both);
    integer ms;
    begin
      ms = floor_ms(erase_time_param * 1000 * x / erase_unit_count_param
                    + erase_offset_param * 1000);
      tmo_ms = both ? ms + 500 : ms + 250 * part;
    end
  endfunction

  task send(input [5:0] i, input a, input [31:0] g, input c);
    integer n;
    @(negedge ref_clk);
    {cmd_index, cmd_is_app, cmd_arg, cmd_crc_ok, cmd_valid} = {i, a, g, c, 1'b1};
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    go = 1'b1;
    got = 1'b0;
    for (n = 0; n < 80 && !got; n = n + 1) begin
      @(posedge ref_clk);
      #1 got = (resp_valid === 1'b1);
    end
    @(negedge ref_clk);
    go = 1'b0;
    // let a last link edge die out before the next command
    repeat (14) @(negedge ref_clk);
  endtask

  task blk(input integer k);
    repeat (k) begin
      @(negedge ref_clk) block_done = 1'b1;
      @(negedge ref_clk) block_done = 1'b0;
    end
    repeat (2) @(negedge ref_clk);
  endtask

  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task t_write;
    chk("erase_time", `BCNT_ERASE_TIME_DEF, erase_time_param);
    chk("erase_units", `BCNT_ERASE_UNITS_DEF, erase_unit_count_param);
    chk("slope_ok", 1, erase_params_ok);
    send(`BCNT_CMD_SET_COUNT, 0, 3, 1);
    chk("answered", 1, got);
    chk("index", `BCNT_CMD_SET_COUNT, resp_index);
    chk("illegal", 0, resp_illegal);
    send(`BCNT_CMD_MULTI_WRITE, 0, 0, 1);
    chk("counted", 1, xfer_counted);
    chk("write", 1, xfer_write);
    blk(2);
    chk("active", 1, xfer_active);
    blk(1);
    chk("ends", 1, n_end);
    blk(1);
    chk("drops", 1, n_drop);
    send(`BCNT_CMD_SET_COUNT, 0, 7, 1);
    send(`BCNT_CMD_SET_COUNT, 0, 1, 1);
    send(`BCNT_CMD_MULTI_WRITE, 0, 0, 1);
    blk(1);
    chk("ends", 2, n_end);
  endtask

  task t_cancel;
    send(`BCNT_CMD_SET_COUNT, 0, 3, 1);
    send(`BCNT_CMD_STATUS, 0, 0, 1);
    send(`BCNT_CMD_MULTI_READ, 0, 0, 1);
    chk("counted", 0, xfer_counted);
    send(`BCNT_CMD_STOP, 0, 0, 1);
    ultra_capacity = 1'b1;
    send(`BCNT_CMD_SET_COUNT, 0, 3, 1);
    send(`BCNT_CMD_STATUS, 0, 0, 1);
    send(`BCNT_CMD_MULTI_READ, 0, 0, 1);
    chk("counted", 1, xfer_counted);
    send(`BCNT_CMD_STOP, 0, 0, 1);
    ultra_capacity = 1'b0;
    send(`BCNT_CMD_SET_COUNT, 0, 0, 1);
    send(`BCNT_CMD_MULTI_READ, 0, 0, 1);
    chk("counted", 0, xfer_counted);
    send(`BCNT_CMD_STOP, 0, 0, 1);
    in_transfer_state = 1'b0;
    send(`BCNT_CMD_SET_COUNT, 0, 2, 1);
    chk("illegal", 1, resp_illegal);
    in_transfer_state = 1'b1;
    send(`BCNT_CMD_SET_COUNT, 0, 2, 0);
    chk("answered", 0, got);
    send(`BCNT_CMD_SET_COUNT, 0, 2, 1);
    send(`BCNT_CMD_MULTI_READ, 0, 0, 1);
    blk(2);
    chk("ends", 3, n_end);
  endtask

  task t_prot;
    send(`BCNT_ACMD_PROT_READ, 1, 0, 1);
    chk("illegal", 1, resp_illegal);
    send(`BCNT_CMD_SET_COUNT, 0, 2, 1);
    send(`BCNT_ACMD_PROT_WRITE, 1, 0, 1);
    chk("illegal", 0, resp_illegal);
    send(`BCNT_CMD_STOP, 0, 0, 1);
    high_capacity = 1'b0;
    send(`BCNT_CMD_SET_COUNT, 0, 2, 1);
    send(`BCNT_CMD_MULTI_READ, 0, 0, 1);
    chk("counted", 0, xfer_counted);
    send(`BCNT_CMD_STOP, 0, 0, 1);
    send(`BCNT_CMD_SET_COUNT, 0, 1, 1);
    send(`BCNT_ACMD_PROT_READ, 1, 0, 1);
    chk("illegal", 0, resp_illegal);
    send(`BCNT_CMD_STOP, 0, 0, 1);
    protected_supported = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("support", 0, card_config_register_cnt_support);
    fast_bus_mode = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("support", 1, card_config_register_cnt_support);
    {high_capacity, protected_supported, fast_bus_mode} = 3'b110;
  endtask

  task t_erase;
    chk("erase_ofs", `BCNT_ERASE_OFS_DEF, erase_offset_param);
    chk("tmo_part", 2750, tmo_ms(1, 1, 0));
    chk("tmo_ends", 7500, tmo_ms(4, 2, 1));
    chk("tmo_floor", 1000, floor_ms(250));
    chk("tmo_keep", 2500, floor_ms(2500));
    chk("tmo_two", 4000, tmo_ms(2, 0, 0));
    // split a two-unit erase at the unit boundary, one small timeout per piece
    repeat (2) begin
      chk("tmo_piece", 2500, tmo_ms(1, 0, 0));
      @(negedge ref_clk) erase_busy = 1'b1;
      repeat (60) @(negedge ref_clk);
      erase_busy = 1'b0;
    end
    @(negedge ref_clk);
    chk("overrun", 0, erase_overrun);
  endtask

  task t_range;
    prev_error = 1'b1;
    send(`BCNT_CMD_SET_COUNT, 0, 16, 1);
    chk("error", 1, resp_error);
    prev_error = 1'b0;
    send(`BCNT_CMD_MULTI_WRITE, 0, 0, 1);
    blk(1);
    user_area_end = 1'b1;
    @(negedge ref_clk) user_area_end = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("range", 1, out_of_range);
    chk("active", 0, xfer_active);
    send(`BCNT_CMD_STOP, 0, 0, 1);
    chk("error", 1, resp_error);
    chk("range", 0, out_of_range);
    erase_busy = 1'b1;
    repeat (90) @(negedge ref_clk);
    chk("overrun", 0, erase_overrun);
    repeat (20) @(negedge ref_clk);
    chk("overrun", 1, erase_overrun);
    erase_busy = 1'b0;
  endtask

  initial begin
    {reset, go, cmd_valid, cmd_is_app, cmd_crc_ok, got} = 6'b100000;
    {in_transfer_state, high_capacity, ultra_capacity, protected_supported} = 4'b1101;
    {fast_bus_mode, prev_error, block_done, user_area_end, erase_busy} = 5'b00000;
    {cmd_index, cmd_arg} = 38'h0;
    {failures, cmp_count, n_end, n_drop} = 128'h0;
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    repeat (2) @(negedge ref_clk);
    t_write;
    t_cancel;
    t_prot;
    t_erase;
    t_range;
    end_sim;
  end

  initial begin
    #300000;
    failures = failures + 1;
    end_sim;
  end
endmodule // block_count_and_erase_timeout_test
